// >>> design/sfq_top.sv
`timescale 1ns/1ns
`default_nettype none
module sfq_top (
  input  wire logic                          clk,
  input  wire logic                          nrst,
  input  wire logic [7:0]                    regAddr,
  input  wire logic                          regRdEn,
  input  wire logic                          regRdFirst,
  input  wire logic                          regWrEn,
  input  wire logic [7:0]                    regWrData,
  output logic      [7:0]                    regRdData,
  input  wire logic                          sampleValid,
  input  wire logic [sfq_pkg::SAMPLE_W-1:0]  sampleData,
  input  wire logic [sfq_pkg::CHAN_W-1:0]    sampleChan,
  output logic                               sampleReady,
  input  wire logic [3:0]                    chanEnable,
  input  wire logic                          activityEvent,
  input  wire logic                          frameSyncPin,
  output logic                               irqPinA,
  output logic                               irqPinB
);
  import sfq_pkg::*;

  logic [7:0]         cfgA_reg;
  logic [7:0]         cfgB_reg;
  logic [7:0]         routeA_reg;
  logic [7:0]         routeB_reg;
  logic [ENTRY_W-1:0] store [0:319];
  logic [PTR_W-1:0]   rdPtr_reg;
  logic [PTR_W-1:0]   wrPtr_reg;
  logic [PTR_W-1:0]   count_reg;
  logic [PTR_W-1:0]   count_next;
  logic               overrun_reg;
  logic               trigSeen_reg;
  logic               frozen_reg;
  logic [PTR_W-1:0]   postCnt_reg;
  sfq_phase_t         phase_reg;
  logic [7:0]         burstAddr_reg;
  logic               fsS1_reg;
  logic               fsS2_reg;
  logic               fsS3_reg;
  logic               fsLevel_reg;

  logic [1:0]         mode;
  logic [PTR_W-1:0]   threshold;
  logic               tagOn;
  logic               pinTrigOn;
  logic [2:0]         nChan;
  logic [PTR_W-1:0]   capacity;
  logic               isEmpty;
  logic               isFull;
  logic               watermark;
  logic               storeOn;
  logic               wr;
  logic               pop;
  logic               needDrop;
  logic [PTR_W-1:0]   advance;
  logic [7:0]         rdAddr;
  logic               dataRead;
  logic [ENTRY_W-1:0] head;
  logic [7:0]         dataByte;
  logic [7:0]         statusByte;
  logic [7:0]         irqSrc;
  logic               fsRise;
  logic               trigger;
  logic               normalLoss;
  logic               trigLoss;
  sfq_phase_t         firstPhase;

  sfq_stream_if inLink ();
  sfq_stream_if drain ();

  // the pair buffer absorbs a stall by the store, e.g. a full store in fill-and-stop mode with no pop
  assign inLink.valid = sampleValid;
  assign inLink.data  = {sampleChan, sampleData};
  assign sampleReady  = inLink.ready;

  sfq_pair_buffer u_buffer (
    .clk  (clk),
    .nrst (nrst),
    .inS  (inLink),
    .outS (drain)
  );

  assign mode      = cfgA_reg[CFGA_MODE_LSB +: 2];
  assign threshold = {cfgA_reg[CFGA_THR_MSB_BIT], cfgB_reg};
  assign tagOn     = cfgA_reg[CFGA_TAG_BIT];
  assign pinTrigOn = cfgA_reg[CFGA_PINTRIG_BIT];

  // whole data sets only; no channel enabled is treated as one
  always_comb begin
    nChan = 3'({2'h0, chanEnable[0]} + {2'h0, chanEnable[1]}
             + {2'h0, chanEnable[2]} + {2'h0, chanEnable[3]});
    if (nChan == 3'h0) begin
      nChan = 3'h1;
    end
  end
  assign capacity = (nChan == THREE_CHAN) ? DEPTH_3CH : DEPTH;

  assign isEmpty   = (count_reg == COUNT_RST);
  assign isFull    = (count_reg == capacity);
  assign watermark = (count_reg >= threshold);

  // frame-sync pin: a change counts once stages two and three agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fsS1_reg    <= 1'b0;
      fsS2_reg    <= 1'b0;
      fsS3_reg    <= 1'b0;
      fsLevel_reg <= 1'b0;
    end else begin
      fsS1_reg <= frameSyncPin;
      fsS2_reg <= fsS1_reg;
      fsS3_reg <= fsS2_reg;
      if (fsS2_reg == fsS3_reg) begin
        fsLevel_reg <= fsS3_reg;
      end
    end
  end
  assign fsRise = (fsS2_reg == fsS3_reg) && fsS3_reg && !fsLevel_reg;

  assign trigger = (mode == MODE_TRIGGER) && !trigSeen_reg
                 && (activityEvent || (pinTrigOn && fsRise));

  // register read path and burst addressing
  assign rdAddr   = regRdFirst ? regAddr : burstAddr_reg;
  assign dataRead = regRdEn && (rdAddr == ADDR_DATA);
  assign head     = store[rdPtr_reg];
  assign firstPhase = tagOn ? PH_TAG : PH_HI;
  assign pop = dataRead && (mode != MODE_OFF) && !isEmpty && (phase_reg == PH_LO);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      burstAddr_reg <= 8'h00;
    end else if (regRdEn) begin
      burstAddr_reg <= (rdAddr == ADDR_DATA) ? ADDR_DATA : rdAddr + 8'h01;
    end
  end

  // a sample is split into bytes; the pop happens on its low byte
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_reg <= PH_HI;
    end else if (mode == MODE_OFF) begin
      phase_reg <= firstPhase;
    end else if (dataRead && !isEmpty) begin
      case (phase_reg)
        PH_TAG:  phase_reg <= PH_HI;
        PH_HI:   phase_reg <= PH_LO;
        PH_LO:   phase_reg <= firstPhase;
        default: phase_reg <= firstPhase;
      endcase
    end else if (isEmpty) begin
      phase_reg <= firstPhase;
    end
  end

  always_comb begin
    dataByte = 8'h00;
    if (mode != MODE_OFF && !isEmpty) begin
      case (phase_reg)
        PH_TAG:  dataByte = {6'h00, head[ENTRY_W-1 -: CHAN_W]};
        PH_HI:   dataByte = head[SAMPLE_W-1 -: 8];
        PH_LO:   dataByte = head[7:0];
        default: dataByte = 8'h00;
      endcase
    end
  end

  always_comb begin
    statusByte                = 8'h00;
    statusByte[STAT_FULL_BIT] = isFull;
    statusByte[STAT_OVR_BIT]  = overrun_reg;
    statusByte[STAT_WM_BIT]   = watermark;
    statusByte[STAT_RDY_BIT]  = !isEmpty;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regRdData <= 8'h00;
    end else if (regRdEn) begin
      case (rdAddr)
        ADDR_STATUS:  regRdData <= statusByte;
        ADDR_DATA:    regRdData <= dataByte;
        ADDR_ROUTE_A: regRdData <= routeA_reg;
        ADDR_ROUTE_B: regRdData <= routeB_reg;
        ADDR_CFG_A:   regRdData <= cfgA_reg;
        ADDR_CFG_B:   regRdData <= cfgB_reg;
        default:      regRdData <= 8'h00;
      endcase
    end
  end

  // register writes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfgA_reg   <= CFG_A_RST;
      cfgB_reg   <= CFG_B_RST;
      routeA_reg <= ROUTE_RST;
      routeB_reg <= ROUTE_RST;
    end else if (regWrEn) begin
      case (regAddr)
        ADDR_CFG_A:   cfgA_reg   <= regWrData;
        ADDR_CFG_B:   cfgB_reg   <= regWrData;
        ADDR_ROUTE_A: routeA_reg <= regWrData;
        ADDR_ROUTE_B: routeB_reg <= regWrData;
        default:      cfgA_reg   <= cfgA_reg;
      endcase
    end
  end

  // store write side: off and frozen discard, fill-and-stop stalls at full
  assign storeOn = (mode != MODE_OFF) && !frozen_reg;
  assign drain.ready = !(storeOn && mode == MODE_NORMAL && isFull && !pop);
  assign wr = drain.valid && drain.ready && storeOn;
  assign needDrop = wr && isFull && !pop && (mode != MODE_NORMAL);

  always_comb begin
    if (pop) begin
      advance = 9'h001;
    end else if (needDrop) begin
      advance = {6'h00, nChan};
    end else begin
      advance = 9'h000;
    end
  end

  function automatic logic [PTR_W-1:0] wrapAdd(input logic [PTR_W-1:0] p,
                                               input logic [PTR_W-1:0] k);
    logic [PTR_W:0] sum;
    sum = {1'b0, p} + {1'b0, k};
    if (sum >= {1'b0, DEPTH}) begin
      sum = sum - {1'b0, DEPTH};
    end
    return sum[PTR_W-1:0];
  endfunction

  assign count_next = count_reg + {8'h00, wr} - advance;

  always_ff @(posedge clk) begin
    if (wr) begin
      store[wrPtr_reg] <= drain.data;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdPtr_reg <= COUNT_RST;
      wrPtr_reg <= COUNT_RST;
      count_reg <= COUNT_RST;
    end else if (mode == MODE_OFF) begin
      rdPtr_reg <= COUNT_RST;
      wrPtr_reg <= COUNT_RST;
      count_reg <= COUNT_RST;
    end else begin
      rdPtr_reg <= wrapAdd(rdPtr_reg, advance);
      wrPtr_reg <= wr ? wrapAdd(wrPtr_reg, 9'h001) : wrPtr_reg;
      count_reg <= count_next;
    end
  end

  // trigger capture: count post-trigger writes, freeze at the threshold
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      trigSeen_reg <= 1'b0;
      frozen_reg   <= 1'b0;
      postCnt_reg  <= COUNT_RST;
    end else if (mode != MODE_TRIGGER) begin
      trigSeen_reg <= 1'b0;
      frozen_reg   <= 1'b0;
      postCnt_reg  <= COUNT_RST;
    end else if (trigger) begin
      trigSeen_reg <= 1'b1;
      postCnt_reg  <= COUNT_RST;
      frozen_reg   <= (threshold == COUNT_RST);
    end else if (trigSeen_reg && wr) begin
      postCnt_reg <= postCnt_reg + 9'h001;
      if (postCnt_reg + 9'h001 >= threshold) begin
        frozen_reg <= 1'b1;
      end
    end
  end

  // overrun: lost input while stalled, or unread set dropped in trigger mode
  assign normalLoss = (mode == MODE_NORMAL) && sampleValid && !inLink.ready;
  assign trigLoss   = (mode == MODE_TRIGGER) && needDrop;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      overrun_reg <= 1'b0;
    end else if (mode == MODE_OFF || mode == MODE_ROLLING) begin
      overrun_reg <= 1'b0;
    end else if (normalLoss || trigLoss) begin
      overrun_reg <= 1'b1;
    end else if (pop) begin
      overrun_reg <= 1'b0;
    end
  end

  // watermark reaches the pins only in fill-and-stop or rolling mode
  always_comb begin
    irqSrc              = statusByte;
    irqSrc[STAT_WM_BIT] = watermark
                        && (mode == MODE_NORMAL || mode == MODE_ROLLING);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irqPinA <= 1'b0;
      irqPinB <= 1'b0;
    end else begin
      irqPinA <= |(irqSrc & routeA_reg);
      irqPinB <= |(irqSrc & routeB_reg);
    end
  end
endmodule
`default_nettype wire

// >>> include/sfq_pkg.sv
package sfq_pkg;

  // byte-wide register map
  localparam logic [7:0] ADDR_STATUS  = 8'h11;
  localparam logic [7:0] ADDR_DATA    = 8'h1d;
  localparam logic [7:0] ADDR_ROUTE_A = 8'h2b;
  localparam logic [7:0] ADDR_ROUTE_B = 8'h2e;
  localparam logic [7:0] ADDR_CFG_A   = 8'h30;
  localparam logic [7:0] ADDR_CFG_B   = 8'h31;

  // sample_queue_config_a fields
  localparam int CFGA_THR_MSB_BIT = 0;
  localparam int CFGA_PINTRIG_BIT = 3;
  localparam int CFGA_MODE_LSB    = 4;
  localparam int CFGA_TAG_BIT     = 6;

  // sample_queue_status fields, shared by both routing registers
  localparam int STAT_FULL_BIT = 1;
  localparam int STAT_OVR_BIT  = 2;
  localparam int STAT_WM_BIT   = 3;
  localparam int STAT_RDY_BIT  = 4;

  // buffer mode codes
  localparam logic [1:0] MODE_OFF     = 2'h0;
  localparam logic [1:0] MODE_NORMAL  = 2'h1;
  localparam logic [1:0] MODE_ROLLING = 2'h2;
  localparam logic [1:0] MODE_TRIGGER = 2'h3;

  // geometry
  localparam int SAMPLE_W = 16;
  localparam int CHAN_W   = 2;
  localparam int ENTRY_W  = SAMPLE_W + CHAN_W;
  localparam int PTR_W    = 9;
  localparam logic [PTR_W-1:0] DEPTH      = 9'h140;
  localparam logic [PTR_W-1:0] DEPTH_3CH  = 9'h13e;
  localparam logic [2:0]       THREE_CHAN = 3'h3;

  // values after reset
  localparam logic [7:0]       CFG_A_RST = 8'h00;
  localparam logic [7:0]       CFG_B_RST = 8'h00;
  localparam logic [7:0]       ROUTE_RST = 8'h00;
  localparam logic [PTR_W-1:0] COUNT_RST = 9'h000;

  // byte phase of a sample being read out
  typedef enum logic [1:0] {
    PH_TAG,
    PH_HI,
    PH_LO
  } sfq_phase_t;

endpackage

// >>> include/sfq_stream_if.sv
`timescale 1ns/1ns
`default_nettype none
interface sfq_stream_if;
  logic                     valid;
  logic                     ready;
  logic [sfq_pkg::ENTRY_W-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> design/sfq_pair_buffer.sv
`timescale 1ns/1ns
`default_nettype none
module sfq_pair_buffer (
  input  wire logic     clk,
  input  wire logic     nrst,
  sfq_stream_if.sink    inS,
  sfq_stream_if.source  outS
);
  import sfq_pkg::*;

  logic [ENTRY_W-1:0] slot0_reg;
  logic [ENTRY_W-1:0] slot1_reg;
  logic [1:0]         fill_reg;
  logic               push;
  logic               pop;

  assign inS.ready  = (fill_reg != 2'h2);
  assign outS.valid = (fill_reg != 2'h0);
  assign outS.data  = slot0_reg;
  assign push       = inS.valid && inS.ready;
  assign pop        = outS.valid && outS.ready;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fill_reg <= 2'h0;
    end else if (push && !pop) begin
      fill_reg <= fill_reg + 2'h1;
    end else if (pop && !push) begin
      fill_reg <= fill_reg - 2'h1;
    end
  end

  // slot0 is always the oldest word
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      slot0_reg <= '0;
      slot1_reg <= '0;
    end else begin
      if (pop) begin
        slot0_reg <= (push && fill_reg == 2'h1) ? inS.data : slot1_reg;
        if (push && fill_reg == 2'h2) begin
          slot1_reg <= inS.data;
        end
      end else if (push) begin
        if (fill_reg == 2'h0) begin
          slot0_reg <= inS.data;
        end else begin
          slot1_reg <= inS.data;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> sim/sfq_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module sfq_host_model (
  input  wire logic       clk,
  output logic [7:0]      regAddr,
  output logic            regRdEn,
  output logic            regRdFirst,
  output logic            regWrEn,
  output logic [7:0]      regWrData,
  input  wire logic [7:0] regRdData
);
  // idle cycles before each read byte, to act as a slow host
  int slow = 0;
  initial begin
    {regAddr, regRdEn, regRdFirst, regWrEn, regWrData} = '0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    #1 {regAddr, regWrData, regWrEn} = {a, v, 1'b1};
    @(posedge clk);
    #1 regWrEn = 1'b0;
  endtask
  // later bytes of a burst follow the internal pointer, so regAddr is ignored
  task automatic rd(input logic f, input logic [7:0] a, output logic [7:0] v);
    repeat (slow) @(posedge clk);
    @(posedge clk);
    #1 {regAddr, regRdFirst, regRdEn} = {a, f, 1'b1};
    @(posedge clk);
    #1 regRdEn = 1'b0;
    v = regRdData;
  endtask
endmodule
`default_nettype wire

// >>> sim/sfq_top_checker.sv
`timescale 1ns/1ns
`default_nettype none
module sfq_checker (
  input wire logic                         clk,
  input wire logic                         nrst,
  input wire logic [7:0]                   regAddr,
  input wire logic                         regRdEn,
  input wire logic                         regRdFirst,
  input wire logic                         regWrEn,
  input wire logic [7:0]                   regWrData,
  input wire logic [7:0]                   regRdData,
  input wire logic                         sampleValid,
  input wire logic [sfq_pkg::SAMPLE_W-1:0] sampleData,
  input wire logic [sfq_pkg::CHAN_W-1:0]   sampleChan,
  input wire logic                         sampleReady,
  input wire logic [3:0]                   chanEnable,
  input wire logic                         activityEvent,
  input wire logic                         frameSyncPin,
  input wire logic                         irqPinA,
  input wire logic                         irqPinB
);
  import sfq_pkg::*;
  logic [1:0] modeQ;
  logic       stRd;
  logic       mapped;
  assign stRd = regRdEn && regRdFirst && regAddr == ADDR_STATUS;
  assign mapped = regAddr inside {ADDR_STATUS, ADDR_DATA, ADDR_ROUTE_A, ADDR_ROUTE_B,
                                  ADDR_CFG_A, ADDR_CFG_B};
  // mode mirror, so off-state checks know when they apply
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      modeQ <= MODE_OFF;
    end else if (regWrEn && regAddr == ADDR_CFG_A) begin
      modeQ <= regWrData[CFGA_MODE_LSB +: 2];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_rd_hold: assert property (!regRdEn |=> $stable(regRdData))
    else $error("read byte changed without a read");
  a_reset_quiet: assert property (disable iff (1'b0) !nrst |->
    regRdData == 8'h00 && !irqPinA && !irqPinB && sampleReady)
    else $error("outputs not quiet in reset");
  a_unmapped_zero: assert property (regRdEn && regRdFirst && !mapped |=>
    regRdData == 8'h00) else $error("unmapped read not zero");
  a_full_ready: assert property (stRd |=>
    !regRdData[STAT_FULL_BIT] || regRdData[STAT_RDY_BIT]) else $error("full without ready");
  a_thr_readback: assert property (regWrEn && regAddr == ADDR_CFG_B ##1 !regWrEn
    ##1 stRd == 1'b0 && regRdEn && regRdFirst && regAddr == ADDR_CFG_B
    |=> regRdData == $past(regWrData, 3)) else $error("threshold readback wrong");
  a_off_data: assert property (regRdEn && regRdFirst && regAddr == ADDR_DATA
    && modeQ == MODE_OFF |=> regRdData == 8'h00) else $error("data read nonzero when off");
  a_off_clean: assert property (stRd && modeQ == MODE_OFF && $past(modeQ) == MODE_OFF
    |=> !regRdData[STAT_OVR_BIT] && !regRdData[STAT_RDY_BIT]) else $error("flags set when off");
  a_off_noirq: assert property (modeQ == MODE_OFF [*4] |-> !irqPinA && !irqPinB)
    else $error("interrupt while off");
  a_ready_cause: assert property (!sampleReady |->
    $past(sampleValid) || !$past(sampleReady)) else $error("input refused without traffic");
  c_full: cover property (stRd ##1 regRdData[STAT_FULL_BIT]);
  c_refused: cover property (sampleValid && !sampleReady);
  c_irq: cover property ($rose(irqPinA));
endmodule
bind sfq_top sfq_checker CHK (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regRdEn(regRdEn),
  .regRdFirst(regRdFirst), .regWrEn(regWrEn), .regWrData(regWrData), .regRdData(regRdData),
  .sampleValid(sampleValid), .sampleData(sampleData), .sampleChan(sampleChan),
  .sampleReady(sampleReady), .chanEnable(chanEnable), .activityEvent(activityEvent),
  .frameSyncPin(frameSyncPin), .irqPinA(irqPinA), .irqPinB(irqPinB));
`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import sfq_pkg::*;
  logic clk, nrst, regRdEn, regRdFirst, regWrEn, sampleValid, sampleReady;
  logic activityEvent, frameSyncPin, irqPinA, irqPinB, tagOn, trig, frz;
  logic [7:0]          regAddr, regWrData, regRdData, d;
  logic [SAMPLE_W-1:0] sampleData;
  logic [CHAN_W-1:0]   sampleChan;
  logic [3:0]          chanEnable;
  logic [1:0]          mode;
  logic [ENTRY_W-1:0]  mq[$];
  int                  thr, nch, cap, post, sn, error_cnt, checked;
  sfq_top DUT (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regRdEn(regRdEn),
    .regRdFirst(regRdFirst), .regWrEn(regWrEn), .regWrData(regWrData), .regRdData(regRdData),
    .sampleValid(sampleValid), .sampleData(sampleData), .sampleChan(sampleChan),
    .sampleReady(sampleReady), .chanEnable(chanEnable), .activityEvent(activityEvent),
    .frameSyncPin(frameSyncPin), .irqPinA(irqPinA), .irqPinB(irqPinB));
  sfq_host_model HOST (.clk(clk), .regAddr(regAddr), .regRdEn(regRdEn),
    .regRdFirst(regRdFirst), .regWrEn(regWrEn), .regWrData(regWrData), .regRdData(regRdData));
  always #5 clk = ~clk;
  task automatic stop_test();
    if (error_cnt == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic model_in(input logic [ENTRY_W-1:0] e);
    if (mode == MODE_OFF || frz) return;
    mq.push_back(e);
    if (mode != MODE_NORMAL && mq.size() > cap) repeat (nch) void'(mq.pop_front());
    post += int'(trig);
    if (trig && post >= thr) frz = 1'b1;
  endtask
  // channel code = index in set; holds only for masks enabling channel 0 upward
  task automatic push(input int n, input int tries);
    logic acc;
    int got;
    got = 0;
    sampleValid = 1'b1;
    sampleData = 16'($urandom);
    sampleChan = 2'(sn % nch);
    while (got < n && tries > 0) begin
      #8 acc = sampleReady;
      @(posedge clk);
      #1 tries--;
      if (acc) begin
        model_in({sampleChan, sampleData});
        got++;
        sn++;
        sampleData = 16'($urandom);
        sampleChan = 2'(sn % nch);
      end
    end
    sampleValid = 1'b0;
  endtask
  task automatic setup(input logic [1:0] m, input logic [8:0] t, input logic [7:0] x,
                       input logic [3:0] ch);
    HOST.wr(ADDR_CFG_A, 8'h00);
    chanEnable = ch;
    HOST.wr(ADDR_CFG_B, t[7:0]);
    HOST.wr(ADDR_CFG_A, x | {2'h0, m, 3'h0, t[8]});
    {mode, tagOn, trig, frz} = {m, x[CFGA_TAG_BIT], 2'b00};
    {thr, post, sn} = {32'(t), 64'h0};
    nch = ch == 4'h0 ? 1 : $countones(ch);
    cap = nch == 3 ? 318 : 320;
    mq.delete();
  endtask
  task automatic stat(input logic ovr);
    int s;
    s = mq.size() > cap ? cap : mq.size();
    repeat (3) @(posedge clk);
    HOST.rd(1'b1, ADDR_STATUS, d);
    chk(d, {3'h0, s > 0, s >= thr, ovr, s == cap, 1'b0});
  endtask
  task automatic drain(input int n);
    logic [ENTRY_W-1:0] e;
    HOST.rd(1'b1, 8'h1c, d);
    chk(d, 8'h00);
    repeat (n) begin
      e = mq.pop_front();
      if (tagOn) begin
        HOST.rd(1'b0, 8'h00, d);
        chk(d, {6'h00, e[17:16]});
      end
      HOST.rd(1'b0, 8'h00, d);
      chk(d, e[15:8]);
      HOST.rd(1'b0, 8'h00, d);
      chk(d, e[7:0]);
    end
  endtask
  task automatic fire(input logic pin);
    @(posedge clk);
    #1 frameSyncPin = pin;
    activityEvent = !pin;
    @(posedge clk);
    #1 activityEvent = 1'b0;
    repeat (5) @(posedge clk);
    #1 frameSyncPin = 1'b0;
    trig = 1'b1;
    frz = thr == 0;
  endtask
  initial begin
    #500000;
    error_cnt++;
    stop_test();
  end
  initial begin
    void'($urandom(32'h1001cbc8));
    {clk, sampleValid, sampleData, sampleChan, chanEnable} = '0;
    // nonblocking, so every reset process is already waiting for the falling edge
    nrst <= 1'b0;
    {activityEvent, frameSyncPin, mode, tagOn, trig, frz} = '0;
    {error_cnt, checked, thr, sn, post} = '0;
    nch = 1;
    cap = 320;
    repeat (4) @(posedge clk);
    #1 nrst = 1'b1;
    stat(1'b0);
    push(3, 3);
    HOST.rd(1'b1, ADDR_DATA, d);
    chk(d, 8'h00);
    stat(1'b0);
    HOST.wr(ADDR_ROUTE_A, 8'h08);
    HOST.wr(ADDR_ROUTE_B, 8'h10);
    setup(MODE_NORMAL, 9'h005, 8'h00, 4'h1);
    HOST.wr(ADDR_CFG_B, 8'h05);
    HOST.rd(1'b1, ADDR_CFG_B, d);
    chk(d, 8'h05);
    push(4, 20);
    stat(1'b0);
    chk({6'h00, irqPinA, irqPinB}, 8'h01);
    push(1, 20);
    stat(1'b0);
    chk({6'h00, irqPinA, irqPinB}, 8'h03);
    drain(2);
    stat(1'b0);
    chk({6'h00, irqPinA, irqPinB}, 8'h01);
    push(cap - 3, 2000);
    stat(1'b0);
    push(10, 8);
    stat(1'b1);
    drain(1);
    stat(1'b0);
    HOST.slow = 2;
    drain(mq.size());
    HOST.slow = 0;
    stat(1'b0);
    setup(MODE_ROLLING, 9'h100, 8'h40, 4'h7);
    push(324, 2000);
    stat(1'b0);
    drain(mq.size());
    stat(1'b0);
    for (int p = 0; p < 2; p++) begin
      setup(MODE_TRIGGER, 9'h004, 8'h08, 4'hf);
      push(10, 40);
      fire(p[0]);
      push(12, 60);
      stat(1'b0);
      chk({6'h00, irqPinA, irqPinB}, 8'h01);
      drain(mq.size());
      stat(1'b0);
    end
    stop_test();
  end
endmodule
`default_nettype wire
